//--- adc_conv_ctrl.v
`include "adc_ctrl_consts.vh"
// strobe decoding, successive approximation sequencing and result latch
module adc_conv_ctrl
(
   input  wire       i_clk,
   input  wire       i_rst,
   input  wire       i_cs_n,
   input  wire       i_wr_n,
   input  wire       i_rd_n,
   input  wire [4:0] i_mux_code,
   input  wire       i_cmp_pos_gt,
   output reg  [7:0] o_result_bus,
   output reg        o_result_bus_oe,
   output reg        o_done_flag_n,
   output reg  [3:0] o_pos_sel,
   output reg  [3:0] o_neg_sel,
   output reg        o_sample_pos,
   output reg        o_sample_neg,
   output reg        o_cmp_strobe,
   output reg  [7:0] o_trial_code,
   output reg        o_busy
);
   localparam [2:0] ST_IDLE = 3'h1;
   localparam [2:0] ST_POS  = 3'h2;
   localparam [2:0] ST_NEG  = 3'h4;
   localparam [`STEP_W-1:0] HALF = `STEP_HALF;
   localparam [`STEP_W-1:0] LAST = `STEP_LAST;

   reg [2:0]           state_q;
   reg [`STEP_W-1:0]   cnt_q;
   reg [`BIT_CNT_W-1:0] bit_q;
   reg [7:0]           mask_q;
   reg [4:0]           code_q;
   reg                 wr_q;
   reg                 rd_act_q;
   reg                 rd_in_wr_q;
   wire [3:0]          pos_d;
   wire [3:0]          neg_d;

   wire sel     = ~i_cs_n;
   wire wr_fall = sel & ~i_wr_n & wr_q;
   wire wr_rise = ~wr_q & i_wr_n & ~i_cs_n;
   wire rd_act  = sel & ~i_rd_n;
   wire rd_end  = rd_act_q & ~rd_act;
   wire start   = wr_rise | rd_end;
   wire load    = wr_rise & i_rd_n & ~rd_in_wr_q;
   // new code seen by the decoder on the loading edge itself
   wire [4:0] code_d = load ? i_mux_code : code_q;
   // trial word after this step's comparator decision
   wire [7:0] kept = i_cmp_pos_gt ? o_trial_code : (o_trial_code & ~mask_q);

   adc_mux_decode u_dec
   (
      .i_code    (code_d),
      .o_pos_sel (pos_d),
      .o_neg_sel (neg_d)
   );

   // strobe tracking and configuration latch
   always @(posedge i_clk)
   begin
      if (i_rst)
      begin
         wr_q       <= 1'b1;
         rd_act_q   <= 1'b0;
         rd_in_wr_q <= 1'b0;
         code_q     <= `CODE_RESET;
      end
      else
      begin
         wr_q     <= i_wr_n;
         rd_act_q <= rd_act;
         if (wr_fall)
            rd_in_wr_q <= ~i_rd_n;
         else if (sel & ~i_wr_n & i_rd_n)
            rd_in_wr_q <= 1'b0;                          // R03
         if (load)
            code_q <= i_mux_code;                        // R04 R10
      end
   end

   // done flag and result bus drive
   always @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_done_flag_n   <= 1'b1;
         o_result_bus_oe <= 1'b0;
         o_result_bus    <= 8'h00;
      end
      else
      begin
         if (wr_fall | rd_act)
            o_done_flag_n <= 1'b1;                       // R11 R13
         else if (state_q == ST_NEG && cnt_q == LAST && bit_q == 3'h0)
            o_done_flag_n <= 1'b0;                       // R12
         o_result_bus_oe <= rd_act;                      // R13 R14
         if (state_q == ST_NEG && cnt_q == LAST && bit_q == 3'h0)
            o_result_bus <= kept;                        // R09 R12
      end
   end

   // successive approximation: one bit per step, msb first
   always @(posedge i_clk)
   begin
      if (i_rst)
      begin
         state_q      <= ST_IDLE;
         cnt_q        <= 8'h00;
         bit_q        <= 3'h7;
         mask_q       <= 8'h00;
         o_trial_code <= 8'h00;
         o_pos_sel    <= 4'h0;
         o_neg_sel    <= 4'h0;
         o_sample_pos <= 1'b0;
         o_sample_neg <= 1'b0;
         o_cmp_strobe <= 1'b0;
         o_busy       <= 1'b0;
      end
      else
      begin
         o_sample_pos <= 1'b0;
         o_sample_neg <= 1'b0;
         o_cmp_strobe <= 1'b0;
         if (start)
         begin
            // restart also covers a write right after a read
            state_q      <= ST_POS;                      // R05 R06 R11
            cnt_q        <= 8'h00;
            bit_q        <= 3'h7;
            mask_q       <= 8'h80;
            o_trial_code <= 8'h80;
            o_pos_sel    <= pos_d;
            o_neg_sel    <= neg_d;
            o_sample_pos <= 1'b1;
            o_busy       <= 1'b1;
         end
         else
         begin
            o_pos_sel <= pos_d;
            o_neg_sel <= neg_d;
            case (state_q)
               ST_IDLE:
                  cnt_q <= 8'h00;
               ST_POS:
               begin
                  cnt_q <= cnt_q + 8'h01;
                  if (cnt_q == HALF - 8'h01)
                  begin
                     o_sample_neg <= 1'b1;               // R07
                     state_q      <= ST_NEG;
                  end
               end
               ST_NEG:
               begin
                  if (cnt_q == LAST)
                  begin
                     o_cmp_strobe <= 1'b1;               // R08
                     cnt_q        <= 8'h00;
                     if (bit_q == 3'h0)
                     begin
                        state_q <= ST_IDLE;
                        o_busy  <= 1'b0;
                     end
                     else
                     begin
                        bit_q        <= bit_q - 3'h1;
                        // trial word drives the comparator reference
                        mask_q       <= mask_q >> 1;
                        o_trial_code <= kept | (mask_q >> 1);
                        o_sample_pos <= 1'b1;
                        state_q      <= ST_POS;
                     end
                  end
                  else
                     cnt_q <= cnt_q + 8'h01;
               end
               default:
                  state_q <= ST_IDLE;
            endcase
         end
      end
   end
endmodule

//--- adc_ctrl_consts.vh
// Summary of operation
// [R01] code bit3/bit4 choose differential, single, pseudo
// [R02] differential: bits2..1 pair, bit0 swaps polarity
// [R03] read low during write keeps old configuration
// [R04] write with read high loads code, starts
// [R05] read presents result and starts new conversion
// [R06] write accepted right after a read
// [R07] negative input sampled half period after positive
// [R08] comparator decision at end of period
// [R09] unsigned 8-bit code, 256 steps
// [R10] code taken from bus only while read high
// [R11] write fall clears done; rise latches, starts
// [R12] conversion within 40 us, then done low
// [R13] chip select and read low: clear done, drive
// [R14] result bus released unless select and read low
`ifndef ADC_CTRL_CONSTS_VH
`define ADC_CTRL_CONSTS_VH
`define CODE_W        5
`define DATA_W        8
`define BIT_MODE      3
`define BIT_PSEUDO    4
`define CONV_TIME_NS  40000
`define CLK_PERIOD_NS 20
`define STEP_CYCLES   ((`CONV_TIME_NS / `CLK_PERIOD_NS) / `DATA_W)
`define STEP_W        8
// half step and last count of a 250-cycle step, sized to the step counter
`define STEP_HALF     8'h7d
`define STEP_LAST     8'hf9
`define BIT_CNT_W     3
`define CODE_RESET    5'h00
`define SEL_NONE      4'hf
`endif

//--- adc_mux_decode.v
`include "adc_ctrl_consts.vh"
// maps the five-bit code to positive / negative channel selections
// channel 0..7 are inputs 1..8, SEL_NONE on negative means analog ground
module adc_mux_decode
(
   input  wire [4:0] i_code,
   output reg  [3:0] o_pos_sel,
   output reg  [3:0] o_neg_sel
);
   // mode decode from bits 3 and 4
   always @*
   begin
      if (!i_code[`BIT_MODE])
      begin
         // pair from bits 2..1, bit 4 ignored
         o_pos_sel = {1'b0, i_code[2:1], i_code[0]};  // R02
         o_neg_sel = {1'b0, i_code[2:1], ~i_code[0]}; // R02
      end
      else if (!i_code[`BIT_PSEUDO])
      begin
         o_pos_sel = {1'b0, i_code[2:0]};             // R01
         o_neg_sel = `SEL_NONE;                       // R01
      end
      else
      begin
         o_pos_sel = {1'b0, i_code[2:0]};             // R01
         o_neg_sel = 4'h7;                            // R01
      end
   end
endmodule

//--- adc_conv_ctrl_monitor.sv
module adc_conv_ctrl_monitor (
   input wire logic       i_clk,
   input wire logic       i_rst,
   input wire logic       i_cs_n,
   input wire logic       i_wr_n,
   input wire logic       i_rd_n,
   input wire logic       o_result_bus_oe,
   input wire logic       o_done_flag_n,
   input wire logic [3:0] o_pos_sel,
   input wire logic       o_sample_pos,
   input wire logic       o_sample_neg,
   input wire logic       o_cmp_strobe,
   input wire logic       o_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   logic        rd_on;
   logic        wr_q;
   logic        rd_q;
   logic [7:0]  pos_age_q;
   logic [11:0] start_age_q;
   assign rd_on = !i_cs_n && !i_rd_n;
   // ages since positive sample and since last start request
   always_ff @(posedge i_clk)
   begin
      wr_q        <= i_wr_n;
      rd_q        <= rd_on;
      pos_age_q   <= o_sample_pos ? 8'h01 : pos_age_q + 8'h01;
      start_age_q <= ((i_wr_n && !wr_q && !i_cs_n) || (rd_q && !rd_on)) ? 12'h001
                     : start_age_q + 12'h001;
   end
   sequence s_wr_rise; !i_cs_n && $rose(i_wr_n); endsequence
   sequence s_rd_end; $fell(rd_on); endsequence
   property p_rd_drive; rd_on |=> o_result_bus_oe && o_done_flag_n; endproperty
   property p_release; !rd_on |=> !o_result_bus_oe; endproperty
   property p_wr_fall; $fell(i_wr_n) && !i_cs_n |=> o_done_flag_n; endproperty
   property p_wr_start; s_wr_rise |=> o_busy && o_sample_pos; endproperty
   property p_rd_start; s_rd_end |=> o_busy && o_sample_pos; endproperty
   property p_keep; s_wr_rise ##0 !i_rd_n |=> $stable(o_pos_sel); endproperty
   property p_neg_half; o_sample_neg |-> pos_age_q == 8'h7d; endproperty
   property p_strobe_end; o_cmp_strobe |-> $past(o_sample_neg, 125); endproperty
   property p_done_time; $fell(o_done_flag_n) |-> start_age_q inside {[1999:2003]}; endproperty
   a_rd_drive: assert property (p_rd_drive) else $error("read did not drive");
   a_release: assert property (p_release) else $error("bus not released");
   a_wr_fall: assert property (p_wr_fall) else $error("done kept on write");
   a_wr_start: assert property (p_wr_start) else $error("write did not start");
   a_rd_start: assert property (p_rd_start) else $error("read did not start");
   a_keep: assert property (p_keep) else $error("config changed");
   a_neg_half: assert property (p_neg_half) else $error("negative sample late");
   a_strobe_end: assert property (p_strobe_end) else $error("strobe mistimed");
   a_done_time: assert property (p_done_time) else $error("conversion time off");
endmodule
bind adc_conv_ctrl adc_conv_ctrl_monitor i_mon (.i_clk, .i_rst, .i_cs_n, .i_wr_n, .i_rd_n,
   .o_result_bus_oe, .o_done_flag_n, .o_pos_sel, .o_sample_pos, .o_sample_neg,
   .o_cmp_strobe, .o_busy);

//--- adc_front_model.sv
module adc_front_model (
   input  wire logic [7:0] i_trial_code,
   input  wire logic [7:0] i_level,
   output logic            o_cmp_pos_gt
);
   timeunit 1ns;
   timeprecision 1ns;
   // plus side at or above trial level
   assign o_cmp_pos_gt = i_level >= i_trial_code;
endmodule

//--- adc_mux_select_and_conversion_control_test.sv
module adc_mux_select_and_conversion_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_clk, i_rst, i_cs_n, i_wr_n, i_rd_n, gt, oe, done_n;
   logic [4:0]  i_mux_code;
   logic [7:0]  level, bus, trial;
   logic [3:0]  pos, neg;
   int          error_cnt, cmp_count, ticks;
   // code, positive select, negative select, level
   logic [20:0] rows [7] = '{21'h000100, 21'h1332ff, 21'h07765a, 21'h0a2f01, 21'h0f7f80,
                             21'h1807fe, 21'h1e673c};
   adc_conv_ctrl i_adc_conv_ctrl (.i_clk, .i_rst, .i_cs_n, .i_wr_n, .i_rd_n, .i_mux_code,
      .i_cmp_pos_gt(gt), .o_result_bus(bus), .o_result_bus_oe(oe), .o_done_flag_n(done_n),
      .o_pos_sel(pos), .o_neg_sel(neg), .o_sample_pos(), .o_sample_neg(), .o_cmp_strobe(),
      .o_trial_code(trial), .o_busy());
   adc_front_model i_adc_front_model (.i_trial_code(trial), .i_level(level), .o_cmp_pos_gt(gt));
   initial
   begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end
   // hang guard
   always @(posedge i_clk)
   begin
      ticks++;
      if (ticks == 40000)
      begin
         error_cnt++;
         report_and_stop;
      end
   end
   task chk(input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e)
      begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task wr(input logic [4:0] c, input logic r);
      @(posedge i_clk) {i_cs_n, i_wr_n, i_rd_n, i_mux_code} <= {2'b00, r, c};
      @(posedge i_clk) i_wr_n <= 1'b1;
      @(posedge i_clk) {i_cs_n, i_rd_n} <= 2'b11;
   endtask
   task rd(input logic [7:0] e);
      @(posedge i_clk) {i_cs_n, i_rd_n} <= 2'b00;
      repeat (2) @(posedge i_clk);
      #1 chk(bus, e);
      chk({oe, done_n}, 8'h03);
      @(posedge i_clk) {i_cs_n, i_rd_n} <= 2'b11;
   endtask
   task wait_done;
      repeat (2100)
      begin
         @(posedge i_clk);
         #1;
         if (done_n === 1'b0) break;
      end
      chk(done_n, 8'h00);
   endtask
   task report_and_stop;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      {i_rst, i_cs_n, i_wr_n, i_rd_n, i_mux_code, level} = {4'hf, 5'h00, 8'h00};
      repeat (12) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk) #1 chk({oe, done_n, pos}, 8'h10);
      $display("test reset done");
      foreach (rows[k])
      begin
         level = rows[k][7:0];
         wr(rows[k][20:16], 1'b1);
         wait_done;
         chk({pos, neg}, rows[k][15:8]);
         rd(rows[k][7:0]);
         $display("test row %0d done", k);
      end
      level = 8'h77;
      wr(5'h00, 1'b0);
      wait_done;
      chk({pos, neg}, 8'h67);
      rd(8'h77);
      $display("test keep done");
      level = 8'h21;
      wait_done;
      chk({pos, neg}, 8'h67);
      wr(5'h0b, 1'b1);
      #1 chk(done_n, 8'h01);
      rd(8'h21);
      level = 8'hc3;
      wr(5'h0c, 1'b1);
      wait_done;
      chk({pos, neg}, 8'h4f);
      rd(8'hc3);
      $display("test back to back done");
      report_and_stop;
   end
endmodule
